// File: verilog/bbc_counter.sv
// eight-stage up/down counter with a shared three-state byte port
`timescale 1ns/100ps
module bbc_counter
	import bbc_pkg::*;
(
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic             clk_en,
	input  wire logic             master_clear_n,
	input  wire logic             sync_clear_n,
	input  wire logic             chip_select_n,
	input  wire logic             load_select_n,
	input  wire logic             drive_enable_n,
	input  wire logic             count_gate_parallel_n,
	input  wire logic             count_gate_trickle_n,
	input  wire logic             count_up,
	input  wire logic [CNT_W-1:0] shared_byte_port_i,
	output logic      [CNT_W-1:0] shared_byte_port_o,
	output logic                  shared_byte_port_oe,
	output logic                  terminal_flag_n
);
	bbc_sync_if #(.W(PIN_W)) pins ();

	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] count_d;
	logic [CNT_W-1:0] flag_count;
	logic             flag_q;
	logic             flag_d;
	logic             oe_q;
	logic             oe_d;
	logic             clear_n;
	logic             cs_s;
	logic             ld_s;
	logic             drv_s;
	logic             sclr_s;
	logic             cep_s;
	logic             cet_s;
	logic             up_s;
	logic [CNT_W-1:0] data_s;
	logic             load_now;
	logic             drive_now;

	function automatic logic [CNT_W-1:0] count_step(input logic [CNT_W-1:0] cnt,
			input logic up);
		count_step = up ? CNT_W'(cnt + COUNT_STEP) : CNT_W'(cnt - COUNT_STEP);
	endfunction : count_step

	function automatic logic at_end(input logic [CNT_W-1:0] cnt, input logic up);
		at_end = up ? (cnt == COUNT_ONES) : (cnt == COUNT_ZERO);
	endfunction : at_end

	// pins arrive from another clock world, so all but master clear, reset and clock enable pass two flops first
	assign pins.raw = {shared_byte_port_i, count_up, count_gate_trickle_n,
		count_gate_parallel_n, sync_clear_n, drive_enable_n, load_select_n, chip_select_n};

	bbc_pin_sync #(
		.W         (PIN_W),
		.RESET_VAL (PIN_RESET)
	) u_pin_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.clk_en   (clk_en),
		.pins     (pins.sync_side)
	);

	assign cs_s   = pins.synced[CTL_CS];
	assign ld_s   = pins.synced[CTL_LD];
	assign drv_s  = pins.synced[CTL_DRV];
	assign sclr_s = pins.synced[CTL_SCLR];
	assign cep_s  = pins.synced[CTL_CEP];
	assign cet_s  = pins.synced[CTL_CET];
	assign up_s   = pins.synced[CTL_UP];
	assign data_s = pins.synced[CTL_DATA +: CNT_W];

	// master clear is not synchronised: it must act without a clock edge;
	// its release is asynchronous, so the source should release it off the edge
	assign clear_n = rst_n & master_clear_n;

	assign load_now  = !cs_s && !ld_s;
	assign drive_now = !cs_s && ld_s && !drv_s;

	always_comb begin
		count_d = count_q;
		if (!clk_en) begin
			count_d = count_q;
		end else if (!sclr_s) begin
			count_d = COUNT_ZERO;
		end else if (load_now) begin
			count_d = data_s;
		end else if (cep_s || cet_s) begin
			count_d = count_q;
		end else begin
			count_d = count_step(count_q, up_s);
		end
	end

	always_comb begin
		flag_count = master_clear_n ? count_d : COUNT_ZERO;
		oe_d       = clk_en ? drive_now : oe_q;
		// flag follows the new count so it changes with it, not an edge later
		flag_d     = clk_en ? !(!cet_s && at_end(flag_count, up_s)) : flag_q;
	end

	always_ff @(posedge core_clk or negedge clear_n) begin
		if (!clear_n) begin
			count_q <= COUNT_ZERO;
		end else begin
			count_q <= count_d;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			oe_q   <= OE_RESET;
			flag_q <= FLAG_IDLE;
		end else begin
			oe_q   <= oe_d;
			flag_q <= flag_d;
		end
	end

	assign shared_byte_port_o  = count_q;
	assign shared_byte_port_oe = oe_q;
	assign terminal_flag_n     = flag_q;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_port_drive_map: assert property (
		clk_en |=> shared_byte_port_oe == $past(!cs_s && ld_s && !drv_s))
		else $error("byte port drive does not follow select and drive pins");

	a_master_clear_zero: assert property (
		!master_clear_n |-> count_q == COUNT_ZERO)
		else $error("count not zero while master clear held");

	a_sync_clear_zero: assert property (
		(clk_en && !sclr_s) |=> count_q == COUNT_ZERO)
		else $error("synchronous clear did not zero the count");

	a_load_takes_port: assert property (
		(clk_en && sclr_s && !cs_s && !ld_s && master_clear_n) ##1 master_clear_n
		|-> count_q == $past(data_s))
		else $error("parallel load did not capture the port value");

	a_gate_holds_count: assert property (
		(clk_en && sclr_s && !(!cs_s && !ld_s) && (cep_s || cet_s) && master_clear_n)
		##1 master_clear_n |-> $stable(count_q))
		else $error("count moved while a count gate was high");

	a_trickle_flag_high: assert property (
		(clk_en && cet_s) |=> terminal_flag_n)
		else $error("terminal flag low while trickle gate high");

	a_count_up_step: assert property (
		(clk_en && sclr_s && (cs_s || ld_s) && !cep_s && !cet_s && up_s && master_clear_n)
		##1 master_clear_n |-> count_q == CNT_W'($past(count_q) + COUNT_STEP))
		else $error("count up did not add one");

	a_count_down_step: assert property (
		(clk_en && sclr_s && (cs_s || ld_s) && !cep_s && !cet_s && !up_s && master_clear_n)
		##1 master_clear_n |-> count_q == CNT_W'($past(count_q) - COUNT_STEP))
		else $error("count down did not subtract one");

	a_freeze_when_idle: assert property (
		(!clk_en && master_clear_n) ##1 master_clear_n |-> $stable(count_q))
		else $error("count changed with clock enable low");

	a_flag_at_limit: assert property (
		!terminal_flag_n |-> (count_q == COUNT_ONES || count_q == COUNT_ZERO))
		else $error("terminal flag low away from a count limit");

	a_up_wrap_zero: assert property (
		(clk_en && sclr_s && (cs_s || ld_s) && !cep_s && !cet_s && up_s && master_clear_n
		&& count_q == COUNT_ONES) ##1 master_clear_n |-> count_q == COUNT_ZERO)
		else $error("count up did not wrap from all ones to zero");

	a_down_wrap_ones: assert property (
		(clk_en && sclr_s && (cs_s || ld_s) && !cep_s && !cet_s && !up_s && master_clear_n
		&& count_q == COUNT_ZERO) ##1 master_clear_n |-> count_q == COUNT_ONES)
		else $error("count down did not wrap from zero to all ones");

	a_flag_up_end: assert property (
		(clk_en && !cet_s && up_s && master_clear_n)
		##1 (master_clear_n && count_q == COUNT_ONES) |-> !terminal_flag_n)
		else $error("terminal flag high at the top count while counting up");

	a_flag_down_end: assert property (
		(clk_en && !cet_s && !up_s && master_clear_n)
		##1 (master_clear_n && count_q == COUNT_ZERO) |-> !terminal_flag_n)
		else $error("terminal flag high at zero while counting down");

	a_flag_wrong_end: assert property (
		(clk_en && master_clear_n) ##1 (master_clear_n
		&& count_q == ($past(up_s) ? COUNT_ZERO : COUNT_ONES)) |-> terminal_flag_n)
		else $error("terminal flag low at the limit of the other direction");

	a_port_off_deselect: assert property (
		(clk_en && cs_s) |=> !shared_byte_port_oe)
		else $error("byte port driven while chip select high");

	a_port_off_load: assert property (
		(clk_en && !ld_s) |=> !shared_byte_port_oe)
		else $error("byte port driven while load select low");

	a_port_off_drive: assert property (
		(clk_en && drv_s) |=> !shared_byte_port_oe)
		else $error("byte port driven while drive enable high");

	a_outputs_freeze: assert property (
		!clk_en |=> $stable(shared_byte_port_oe) && $stable(terminal_flag_n))
		else $error("drive or flag changed with clock enable low");
endmodule : bbc_counter

// File: pkg/bbc_pkg.sv
// constants shared by the bus counter and its input synchroniser
package bbc_pkg;
	localparam int unsigned CNT_W       = 8;
	localparam logic [7:0]  COUNT_ZERO  = 8'h00;
	localparam logic [7:0]  COUNT_ONES  = 8'hFF;
	localparam logic [7:0]  COUNT_STEP  = 8'h01;
	localparam logic        FLAG_IDLE   = 1'b1;
	localparam logic        OE_RESET    = 1'b0;
	localparam int unsigned SYNC_STAGES = 2;
	// positions in the synchronised pin vector
	localparam int unsigned CTL_CS      = 0;
	localparam int unsigned CTL_LD      = 1;
	localparam int unsigned CTL_DRV     = 2;
	localparam int unsigned CTL_SCLR    = 3;
	localparam int unsigned CTL_CEP     = 4;
	localparam int unsigned CTL_CET     = 5;
	localparam int unsigned CTL_UP      = 6;
	localparam int unsigned CTL_DATA    = 7;
	localparam int unsigned PIN_W       = CTL_DATA + CNT_W;
	localparam logic [14:0] PIN_RESET   = 15'h007F;
endpackage : bbc_pkg

// File: pkg/bbc_sync_if.sv
// raw pin vector and its synchronised copy between counter and synchroniser
`timescale 1ns/100ps
interface bbc_sync_if #(parameter int unsigned W = 15);
	logic [W-1:0] raw;
	logic [W-1:0] synced;
	modport sync_side (input raw, output synced);
	modport user_side (output raw, input synced);
endinterface : bbc_sync_if

// File: verilog/bbc_pin_sync.sv
// two-stage synchroniser for the counter's control and data pins
`timescale 1ns/100ps
module bbc_pin_sync
	import bbc_pkg::*;
#(
	parameter int unsigned      W         = PIN_W,
	parameter logic [W-1:0]     RESET_VAL = PIN_RESET
) (
	input  wire logic           core_clk,
	input  wire logic           rst_n,
	input  wire logic           clk_en,
	bbc_sync_if.sync_side       pins
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] stable_q;
	logic [W-1:0] stable_d;

	// first stage feeds only the second; nothing else looks at meta_q
	always_comb begin
		meta_d   = clk_en ? pins.raw : meta_q;
		stable_d = clk_en ? meta_q : stable_q;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q   <= RESET_VAL;
			stable_q <= RESET_VAL;
		end else begin
			meta_q   <= meta_d;
			stable_q <= stable_d;
		end
	end

	assign pins.synced = stable_q;
endmodule : bbc_pin_sync

// File: test/bbc_bus_master.sv
// bus master model: resolves the shared byte wire from both drivers
`timescale 1ns/100ps
module bbc_bus_master (
	input  wire logic       core_clk,
	input  wire logic [7:0] dev_o,
	input  wire logic       dev_oe,
	input  wire logic [7:0] mst_o,
	input  wire logic       mst_oe,
	output logic      [7:0] wire_v
);
	logic [7:0] float_q = 8'h5A;
	// no pull-up: a floating wire shows a changing pattern, never a stale value
	always @(posedge core_clk) float_q <= ~float_q;
	always_comb begin
		if (dev_oe && mst_oe) wire_v = 'x;
		else if (dev_oe) wire_v = dev_o;
		else if (mst_oe) wire_v = mst_o;
		else wire_v = float_q;
	end
endmodule : bbc_bus_master

// File: test/bbc_counter_test.sv
// self-checking bench for the bus counter
`timescale 1ns/100ps
module bbc_counter_test;
	import bbc_pkg::*;
	logic       core_clk = 1'b0, rst_n = 1'b0, mclr_n = 1'b1, mst_oe = 1'b0, en = 1'b1;
	logic [6:0] p = 7'h7F;
	logic [7:0] mst_o = 8'h00, wire_v, port_o, d;
	logic       oe, flag_n;
	logic [9:0] expq[$];
	int         error_cnt = 0, n_tests = 0;
	// pin order {cs, load, drive, sync clear, gate p, gate t, up}
	localparam logic [6:0] HLD = 7'h7F, LDP = 7'h1F, RD = 7'h2F, UPC = 7'h79, DNC = 7'h78;
	localparam logic [6:0] HTU = 7'h7D, HTD = 7'h7C, SCL = 7'h71;
	always #2 core_clk = ~core_clk;
	bbc_counter dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(en),
		.master_clear_n(mclr_n), .sync_clear_n(p[3]), .chip_select_n(p[6]),
		.load_select_n(p[5]), .drive_enable_n(p[4]), .count_gate_parallel_n(p[2]),
		.count_gate_trickle_n(p[1]), .count_up(p[0]), .shared_byte_port_i(wire_v),
		.shared_byte_port_o(port_o), .shared_byte_port_oe(oe), .terminal_flag_n(flag_n));
	bbc_bus_master bm (.core_clk(core_clk), .dev_o(port_o), .dev_oe(oe), .mst_o(mst_o),
		.mst_oe(mst_oe), .wire_v(wire_v));
	task automatic conclude;
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : conclude
	task automatic check(input string nm, input logic [9:0] e, input logic [9:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : check
	// the master drives the wire only while it asks for a load
	task automatic pins(input logic [6:0] np, input logic [7:0] dat, input int n);
		@(negedge core_clk);
		p = np;
		mst_o = dat;
		mst_oe = !np[6] && !np[5];
		repeat (n) @(negedge core_clk);
	endtask : pins
	task automatic expect_out(input logic [7:0] v, input logic o, input logic f);
		expq.push_back({v, o, f});
		@(negedge core_clk);
	endtask : expect_out
	always @(negedge core_clk) begin
		if (expq.size() > 0) check("count_oe_flag", expq.pop_front(), {port_o, oe, flag_n});
	end
	initial begin
		#20000;
		error_cnt++;
		conclude();
	end
	initial begin
		void'($urandom(32'h7077BB37));
		repeat (6) @(negedge core_clk);
		rst_n = 1'b1;
		d = 8'($urandom());
		pins(LDP, d, 4);
		expect_out(d, 1'b0, 1'b1);
		pins(RD, 8'h00, 4);
		expect_out(d, 1'b1, 1'b1);
		pins(HLD, 8'h00, 4);
		expect_out(d, 1'b0, 1'b1);
		pins(LDP, 8'hFE, 4);
		pins(UPC, 8'h00, 2);
		pins(HTU, 8'h00, 4);
		expect_out(8'h01, 1'b0, 1'b1);
		pins(LDP, 8'hFE, 4);
		pins(UPC, 8'h00, 0);
		pins(HTU, 8'h00, 4);
		expect_out(8'hFF, 1'b0, 1'b0);
		pins(HLD, 8'h00, 4);
		expect_out(8'hFF, 1'b0, 1'b1);
		pins(LDP, 8'h02, 4);
		pins(DNC, 8'h00, 2);
		pins(HLD, 8'h00, 4);
		expect_out(8'hFF, 1'b0, 1'b1);
		pins(LDP, 8'h01, 4);
		pins(DNC, 8'h00, 0);
		pins(HTD, 8'h00, 4);
		expect_out(8'h00, 1'b0, 1'b0);
		pins(LDP, 8'h80, 4);
		pins(SCL, 8'h00, 1);
		pins(HLD, 8'h00, 4);
		expect_out(8'h00, 1'b0, 1'b1);
		pins(LDP, d | 8'h01, 4);
		pins(HLD, 8'h00, 3);
		mclr_n = 1'b0;
		@(negedge core_clk);
		expect_out(8'h00, 1'b0, 1'b1);
		mclr_n = 1'b1;
		pins(HLD, 8'h00, 4);
		expect_out(8'h00, 1'b0, 1'b1);
		// pins set while the enable is low are not sampled; they act once the enable returns, while still on the inputs
		pins(LDP, 8'h10, 4);
		en = 1'b0;
		pins(UPC, 8'h00, 4);
		expect_out(8'h10, 1'b0, 1'b1);
		en = 1'b1;
		pins(HTU, 8'h00, 4);
		expect_out(8'h11, 1'b0, 1'b1);
		conclude();
	end
endmodule : bbc_counter_test
